// ### include/sgbs_defines.svh
// Register map, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the gain switcher sources.
`ifndef SGBS_DEFINES_SVH
`define SGBS_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SGBS_OFS_CFG      12'h000
`define SGBS_OFS_ROT_ACC  12'h004
`define SGBS_OFS_LIN_ACC  12'h008
`define SGBS_OFS_DEV_THR  12'h00C
`define SGBS_OFS_WAIT1    12'h010
`define SGBS_OFS_WAIT2    12'h014
`define SGBS_OFS_RAMP1    12'h018
`define SGBS_OFS_RAMP2    12'h01C
`define SGBS_OFS_STATUS   12'h020
`define SGBS_OFS_BANK1    12'h040
`define SGBS_OFS_BANK2    12'h060
`define SGBS_BANK_MASK    12'hFE0

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define SGBS_MODE_LSB     0
`define SGBS_MODE_MSB     3
`define SGBS_CSEL_LSB     4
`define SGBS_CSEL_MSB     6
`define SGBS_LINEAR_BIT   8
`define SGBS_PIDEV_BIT    9
`define SGBS_MODE_MANUAL  4'h0
`define SGBS_MODE_AUTO    4'h2

// ----------------------------------------
// Reset values and ranges
// ----------------------------------------
`define SGBS_RST_VGAIN    16'h0190
`define SGBS_RST_INTEG    16'h07D0
`define SGBS_RST_PGAIN    16'h0190
`define SGBS_RST_TFILT    16'h0064
`define SGBS_RST_FFWD     16'h0000
`define SGBS_INTEG_MIN    16'h000F
`define SGBS_INTEG_MAX    16'hC800
`define SGBS_IDX_INTEG    3'h1
`define SGBS_IDX_GINTEG   3'h6

// ----------------------------------------
// Timing: control cycle derived from clock
// ----------------------------------------
`define SGBS_CLK_NS       10
`define SGBS_CTRL_NS      1000
`define SGBS_CTRL_CYC     (`SGBS_CTRL_NS / `SGBS_CLK_NS)

`endif

// ### include/sgbs_pkg.sv
// Types shared by the gain bank switcher modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sgbs_pkg;
	// Measured loop quantities
	typedef struct packed {
		logic [15:0] accel;
		logic [15:0] pos_dev;
	} sgbs_sense_t;
	// Positioning status signals
	typedef struct packed {
		logic positioning_complete;
		logic near;
		logic filt_idle;
		logic pulse_on;
	} sgbs_posn_t;
	// Eight blended gains
	typedef logic [7:0][15:0] sgbs_gains_t;
	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_FIRST  = 6'h01,
		ST_WUP    = 6'h02,
		ST_RUP    = 6'h04,
		ST_SECOND = 6'h08,
		ST_WDN    = 6'h10,
		ST_RDN    = 6'h20
	} sgbs_state_t;
endpackage
`default_nettype wire

// ### logic/sgbs_cond.sv
// Condition A evaluation and the P/PI forcing decision.
// Assumes inputs synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module sgbs_cond (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic [2:0]        csel_i,
	input  wire logic              linear_i,
	input  wire logic              pi_dev_i,
	input  wire logic              pos_mode_i,
	input  wire logic [15:0]       rot_thr_i,
	input  wire logic [15:0]       lin_thr_i,
	input  wire logic [15:0]       dev_thr_i,
	input  wire sgbs_pkg::sgbs_sense_t sense_i,
	input  wire sgbs_pkg::sgbs_posn_t  posn_i,
	output logic                   cond_a_o,
	output logic                   p_ctrl_o
);
	import sgbs_pkg::*;
	logic cond_raw;   // Condition A in position control
	logic cond_d;     // Condition with mode fixing
	logic pctl_d;     // Next P control request

	// Select condition A; unused codes count as not met
	always_comb begin
		unique case (csel_i)
			3'h0: cond_raw = posn_i.positioning_complete;
			3'h1: cond_raw = !posn_i.positioning_complete;
			3'h2: cond_raw = posn_i.near;
			3'h3: cond_raw = !posn_i.near;
			3'h4: cond_raw = posn_i.filt_idle && !posn_i.pulse_on;
			3'h5: cond_raw = posn_i.pulse_on;
			default: cond_raw = 1'b0;
		endcase
		// Odd codes hold second bank outside position control
		cond_d = pos_mode_i ? cond_raw : csel_i[0];
	end

	// Deviation test when selected, else acceleration test per motor type
	always_comb begin
		if (pi_dev_i) begin
			pctl_d = pos_mode_i && (sense_i.pos_dev > dev_thr_i);
		end else if (linear_i) begin
			pctl_d = sense_i.accel > lin_thr_i;
		end else begin
			pctl_d = sense_i.accel > rot_thr_i;
		end
	end

	// Registered outputs keep loop inputs glitch free
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cond_a_o <= 1'b0;
			p_ctrl_o <= 1'b0;
		end else begin
			cond_a_o <= cond_d;
			p_ctrl_o <= pctl_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_rot_accel_pctl: assert property (!pi_dev_i && !linear_i && sense_i.accel > rot_thr_i
		|=> p_ctrl_o) else $error("rotary accel did not force P");
	a_lin_accel_pctl: assert property (!pi_dev_i && linear_i && sense_i.accel > lin_thr_i
		|=> p_ctrl_o) else $error("linear accel did not force P");
	a_dev_pos_only: assert property (pi_dev_i && !pos_mode_i
		|=> !p_ctrl_o) else $error("deviation test outside position");
	a_positioning_complete_cond: assert property (pos_mode_i && csel_i == 3'h0
		|=> cond_a_o == $past(posn_i.positioning_complete)) else $error("positioning_complete condition wrong");
	a_fixed_bank: assert property (!pos_mode_i && csel_i <= 3'h5
		|=> cond_a_o == $past(csel_i[0])) else $error("fixed bank wrong");
endmodule // sgbs_cond
`default_nettype wire

// ### logic/sgbs_ramp.sv
// Wait and linear ramp sequencer between the two gain banks.
// Assumes tick_i is a one-cycle pulse per control cycle.
`timescale 1ns/100ps
`default_nettype none
module sgbs_ramp (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        tick_i,
	input  wire logic        manual_i,
	input  wire logic        msel_i,
	input  wire logic        tgt_i,
	input  wire logic [15:0] wait1_i,
	input  wire logic [15:0] wait2_i,
	input  wire logic [15:0] ramp1_i,
	input  wire logic [15:0] ramp2_i,
	output logic [15:0]      num_o,
	output logic [15:0]      den_o,
	output logic             busy_o,
	output logic             second_o
);
	import sgbs_pkg::*;
	sgbs_state_t state_q;    // Sequencer state
	logic [15:0] cnt_q;      // Control cycles in state

	// Sequencer; manual mode snaps straight to the selected bank
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_q <= ST_FIRST;
			cnt_q   <= 16'h0000;
		end else if (manual_i) begin
			state_q <= msel_i ? ST_SECOND : ST_FIRST;
			cnt_q   <= 16'h0000;
		end else if (tick_i) begin
			cnt_q <= cnt_q + 16'h0001;
			unique case (state_q)
				ST_FIRST: begin
					cnt_q <= 16'h0000;
					if (tgt_i) state_q <= ST_WUP;
				end
				ST_WUP: begin
					if (!tgt_i) begin
						state_q <= ST_FIRST;           // Pending switch cancelled
					end else if (cnt_q >= wait1_i) begin
						state_q <= ST_RUP;
						cnt_q   <= 16'h0000;
					end
				end
				ST_RUP: begin
					if (cnt_q >= ramp1_i) state_q <= ST_SECOND;
				end
				ST_SECOND: begin
					cnt_q <= 16'h0000;
					if (!tgt_i) state_q <= ST_WDN;
				end
				ST_WDN: begin
					if (tgt_i) begin
						state_q <= ST_SECOND;
					end else if (cnt_q >= wait2_i) begin
						state_q <= ST_RDN;
						cnt_q   <= 16'h0000;
					end
				end
				ST_RDN: begin
					if (cnt_q >= ramp2_i) state_q <= ST_FIRST;
				end
			endcase
		end
	end

	// Blend fraction toward the second bank; zero ramp time gives a step
	always_comb begin
		num_o = 16'h0000;
		den_o = 16'h0001;
		unique case (state_q)
			ST_FIRST, ST_WUP: num_o = 16'h0000;
			ST_SECOND, ST_WDN: num_o = 16'h0001;
			ST_RUP: begin
				num_o = cnt_q;
				den_o = (ramp1_i == 16'h0000) ? 16'h0001 : ramp1_i;
			end
			ST_RDN: begin
				num_o = ramp2_i - cnt_q;
				den_o = (ramp2_i == 16'h0000) ? 16'h0001 : ramp2_i;
			end
		endcase
		busy_o   = (state_q == ST_RUP) || (state_q == ST_RDN);
		second_o = (state_q == ST_SECOND);
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_wait_done;
		state_q == ST_WUP && tick_i && !manual_i && tgt_i && cnt_q >= wait1_i;
	endsequence
	a_wait_then_ramp: assert property (s_wait_done |=> state_q == ST_RUP && cnt_q == 16'h0000)
		else $error("ramp did not follow wait");
	a_down_start: assert property (state_q == ST_SECOND && tick_i && !manual_i && !tgt_i
		|=> state_q == ST_WDN) else $error("return wait not started");
	a_wait_cancel: assert property (state_q == ST_WUP && tick_i && !manual_i && !tgt_i
		|=> state_q == ST_FIRST) else $error("pending switch not cancelled");
	a_ramp_step: assert property (state_q == ST_RUP && tick_i && !manual_i && cnt_q < ramp1_i
		|=> state_q == ST_RUP && num_o == $past(num_o) + 16'h0001)
		else $error("ramp did not advance");
endmodule // sgbs_ramp
`default_nettype wire

// ### logic/sgbs_top.sv
// Servo gain bank switcher: APB registers, two gain banks,
// manual or automatic bank selection with wait and linear ramp,
// and the velocity loop P/PI forcing flag.
// Assumes an APB master on clk_i and loop signals synchronous to it.
//
// Operation
// - rotary motor: acceleration over threshold forces P
// - linear motor: acceleration over threshold forces P
// - deviation over threshold forces P, position only
// - mode digit 0 manual, 2 automatic, 1 reserved
// - manual: select input on gives second bank
// - each bank holds eight loop gains
// - condition A true: wait one, ramp one
// - condition A false: wait two, ramp two
// - selector digit picks condition A source
// - outside position control, bank fixed by code
// - after wait, gains ramp linearly old to new
// - first integral time 15..51200, resets 2000
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "sgbs_defines.svh"
`default_nettype none
module sgbs_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// APB slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Loop side
	input  wire logic                  pos_mode_i,
	input  wire logic                  gain_sel_i,
	input  wire sgbs_pkg::sgbs_sense_t sense_i,
	input  wire sgbs_pkg::sgbs_posn_t  posn_i,
	output sgbs_pkg::sgbs_gains_t      gains_o,
	output logic                       p_ctrl_o,
	output logic                       second_o
);
	import sgbs_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [15:0] cfg_q;          // Mode, selector, motor type
	logic [15:0] rot_thr_q;      // rotary_accel_threshold
	logic [15:0] lin_thr_q;      // linear_accel_threshold
	logic [15:0] dev_thr_q;      // deviation_threshold
	logic [15:0] wait1_q;        // wait_time_one, control cycles
	logic [15:0] wait2_q;        // wait_time_two
	logic [15:0] ramp1_q;        // ramp_time_one
	logic [15:0] ramp2_q;        // ramp_time_two
	logic [15:0] bank1_q [8];    // First bank values
	logic [15:0] bank2_q [8];    // Second bank values
	logic [6:0]  div_q;          // Control cycle divider
	logic        tick;           // One pulse per control cycle
	logic        setup;          // APB setup phase
	logic        access;         // APB access phase
	logic        wr_en;          // Write taken this edge
	logic        mapped;         // Address decodes
	logic [15:0] wval;           // Write value, low half
	logic [2:0]  widx;           // Bank word index
	logic [31:0] rdata;          // Read mux
	logic        manual;         // Manual selection active
	logic        cond_a;         // Condition A after fixing
	logic        busy;           // Ramp in progress
	logic [15:0] num;            // Blend numerator
	logic [15:0] den;            // Blend denominator

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Reset value of bank word i; both banks share the defaults
	function automatic logic [15:0] rst_val(input logic [2:0] i);
		unique case (i)
			3'h0, 3'h5: rst_val = `SGBS_RST_VGAIN;
			3'h1, 3'h6: rst_val = `SGBS_RST_INTEG;
			3'h2, 3'h7: rst_val = `SGBS_RST_PGAIN;
			3'h3:       rst_val = `SGBS_RST_TFILT;
			3'h4:       rst_val = `SGBS_RST_FFWD;
		endcase
	endfunction

	// Integral time words are held inside their legal range
	function automatic logic [15:0] clamp(input logic [2:0] i, input logic [15:0] v);
		if (i != `SGBS_IDX_INTEG && i != `SGBS_IDX_GINTEG) begin
			clamp = v;
		end else if (v < `SGBS_INTEG_MIN) begin
			clamp = `SGBS_INTEG_MIN;
		end else if (v > `SGBS_INTEG_MAX) begin
			clamp = `SGBS_INTEG_MAX;
		end else begin
			clamp = v;
		end
	endfunction

	// Linear interpolation a + (b - a) * n / d
	function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] n, input logic [15:0] d);
		logic signed [16:0] df;
		logic signed [33:0] pr;
		logic signed [33:0] qt;
		df   = $signed({1'b0, b}) - $signed({1'b0, a});
		pr   = df * $signed({1'b0, n});
		qt   = pr / $signed({18'h0_0000, d});
		lerp = a + qt[15:0];
	endfunction

	// ----------------------------------------
	// Control cycle divider
	// ----------------------------------------
	// Gain ramp and timers step once per control cycle, not per clock
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || tick) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end
	assign tick = (div_q == 7'(`SGBS_CTRL_CYC - 1));

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	always_comb begin
		setup  = psel_i && !penable_i;
		access = psel_i && penable_i;
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		widx   = paddr_i[4:2];
		wval   = pwdata_i[15:0];
		unique case (paddr_i & `SGBS_BANK_MASK)
			`SGBS_OFS_BANK1: rdata = {16'h0000, bank1_q[widx]};
			`SGBS_OFS_BANK2: rdata = {16'h0000, bank2_q[widx]};
			default: begin
				unique case (paddr_i)
					`SGBS_OFS_CFG:     rdata = {16'h0000, cfg_q};
					`SGBS_OFS_ROT_ACC: rdata = {16'h0000, rot_thr_q};
					`SGBS_OFS_LIN_ACC: rdata = {16'h0000, lin_thr_q};
					`SGBS_OFS_DEV_THR: rdata = {16'h0000, dev_thr_q};
					`SGBS_OFS_WAIT1:   rdata = {16'h0000, wait1_q};
					`SGBS_OFS_WAIT2:   rdata = {16'h0000, wait2_q};
					`SGBS_OFS_RAMP1:   rdata = {16'h0000, ramp1_q};
					`SGBS_OFS_RAMP2:   rdata = {16'h0000, ramp2_q};
					`SGBS_OFS_STATUS:  rdata = {28'h000_0000, cond_a, p_ctrl_o, busy, second_o};
					default:           mapped = 1'b0;
				endcase
			end
		endcase
		// Misaligned addresses are not mapped
		if (paddr_i[1:0] != 2'h0) mapped = 1'b0;
		wr_en = access && pwrite_i && mapped;
	end

	// Zero wait state: read data is captured during setup
	assign pready_o  = 1'b1;
	assign pslverr_o = access && !mapped;

	// Read data register
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup) begin
			prdata_o <= rdata;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Reserved mode codes are refused so the block never runs in one
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			cfg_q <= 16'h0000;
		end else if (wr_en && paddr_i == `SGBS_OFS_CFG) begin
			cfg_q[15:`SGBS_MODE_MSB+1] <= wval[15:`SGBS_MODE_MSB+1];
			if (wval[`SGBS_MODE_MSB:`SGBS_MODE_LSB] == `SGBS_MODE_MANUAL ||
				wval[`SGBS_MODE_MSB:`SGBS_MODE_LSB] == `SGBS_MODE_AUTO) begin
				cfg_q[`SGBS_MODE_MSB:`SGBS_MODE_LSB] <= wval[`SGBS_MODE_MSB:`SGBS_MODE_LSB];
			end
		end
	end

	// Thresholds and timing words
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rot_thr_q <= 16'h0000;
			lin_thr_q <= 16'h0000;
			dev_thr_q <= 16'h0000;
			wait1_q   <= 16'h0000;
			wait2_q   <= 16'h0000;
			ramp1_q   <= 16'h0000;
			ramp2_q   <= 16'h0000;
		end else if (wr_en) begin
			unique case (paddr_i)
				`SGBS_OFS_ROT_ACC: rot_thr_q <= wval;
				`SGBS_OFS_LIN_ACC: lin_thr_q <= wval;
				`SGBS_OFS_DEV_THR: dev_thr_q <= wval;
				`SGBS_OFS_WAIT1:   wait1_q   <= wval;
				`SGBS_OFS_WAIT2:   wait2_q   <= wval;
				`SGBS_OFS_RAMP1:   ramp1_q   <= wval;
				`SGBS_OFS_RAMP2:   ramp2_q   <= wval;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Gain banks
	// ----------------------------------------
	// Eight words per bank, taking effect at once on write
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 8; i++) begin
				bank1_q[i] <= rst_val(3'(i));
				bank2_q[i] <= rst_val(3'(i));
			end
		end else if (wr_en) begin
			if ((paddr_i & `SGBS_BANK_MASK) == `SGBS_OFS_BANK1) begin
				bank1_q[widx] <= clamp(widx, wval);
			end
			if ((paddr_i & `SGBS_BANK_MASK) == `SGBS_OFS_BANK2) begin
				bank2_q[widx] <= clamp(widx, wval);
			end
		end
	end

	// ----------------------------------------
	// Condition and sequencer
	// ----------------------------------------
	assign manual = (cfg_q[`SGBS_MODE_MSB:`SGBS_MODE_LSB] != `SGBS_MODE_AUTO);

	sgbs_cond u_cond (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.csel_i     (cfg_q[`SGBS_CSEL_MSB:`SGBS_CSEL_LSB]),
		.linear_i   (cfg_q[`SGBS_LINEAR_BIT]),
		.pi_dev_i   (cfg_q[`SGBS_PIDEV_BIT]),
		.pos_mode_i (pos_mode_i),
		.rot_thr_i  (rot_thr_q),
		.lin_thr_i  (lin_thr_q),
		.dev_thr_i  (dev_thr_q),
		.sense_i    (sense_i),
		.posn_i     (posn_i),
		.cond_a_o   (cond_a),
		.p_ctrl_o   (p_ctrl_o)
	);

	// Manual mode follows the select input directly
	sgbs_ramp u_ramp (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.tick_i   (tick),
		.manual_i (manual),
		.msel_i   (gain_sel_i),
		.tgt_i    (cond_a),
		.wait1_i  (wait1_q),
		.wait2_i  (wait2_q),
		.ramp1_i  (ramp1_q),
		.ramp2_i  (ramp2_q),
		.num_o    (num),
		.den_o    (den),
		.busy_o   (busy),
		.second_o (second_o)
	);

	// ----------------------------------------
	// Blended gain outputs
	// ----------------------------------------
	// One divider per word; area traded for a fixed one-cycle latency
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < 8; i++) begin
				gains_o[i] <= rst_val(3'(i));
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				gains_o[i] <= lerp(bank1_q[i], bank2_q[i], num, den);
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_mode_reserved: assert property (wr_en && paddr_i == `SGBS_OFS_CFG
		&& wval[`SGBS_MODE_MSB:`SGBS_MODE_LSB] == 4'h1
		|=> $stable(cfg_q[`SGBS_MODE_MSB:`SGBS_MODE_LSB]))
		else $error("reserved mode accepted");
	a_manual_bank: assert property (manual && gain_sel_i ##1 manual && gain_sel_i
		|=> gains_o[0] == bank2_q[0]) else $error("manual second bank missing");
	a_manual_first: assert property (manual && !gain_sel_i ##1 manual && !gain_sel_i
		|=> gains_o[2] == bank1_q[2]) else $error("manual first bank missing");
	a_integ_range: assert property (bank1_q[1] >= `SGBS_INTEG_MIN && bank1_q[1] <= `SGBS_INTEG_MAX)
		else $error("integral time out of range");
	a_integ_write: assert property (wr_en && paddr_i == `SGBS_OFS_BANK1 + 12'h004
		|=> bank1_q[1] == $past(clamp(`SGBS_IDX_INTEG, wval)))
		else $error("integral not immediate");
endmodule // sgbs_top
`default_nettype wire

// ### sim/sgbs_host_model.sv
// Host controller model: select input, positioning status, loop values.
// Assumes the bench calls drive() from its main process.
`timescale 1ns/100ps
`default_nettype none
module sgbs_host_model (
	input  wire logic             clk_i,
	output logic                  gain_sel_o,
	output logic                  pos_mode_o,
	output sgbs_pkg::sgbs_posn_t  posn_o,
	output sgbs_pkg::sgbs_sense_t sense_o
);
	import sgbs_pkg::*;
	// Quiet levels from time zero
	initial begin
		gain_sel_o = 1'b0;
		pos_mode_o = 1'b0;
		posn_o     = '0;
		sense_o    = '0;
	end
	// New levels launched just after an edge, held until the next call
	task automatic drive(input logic gs, input logic pm, input logic [3:0] ps,
		input logic [15:0] acc, input logic [15:0] dev);
		@(posedge clk_i);
		gain_sel_o <= gs;
		pos_mode_o <= pm;
		posn_o     <= ps;
		sense_o    <= {acc, dev};
	endtask
endmodule // sgbs_host_model
`default_nettype wire

// ### sim/sgbs_top_tb_top.sv
// Self-checking bench for the gain bank switcher.
// Assumes sgbs_pkg and the host model are compiled first.
`timescale 1ns/100ps
`include "sgbs_defines.svh"
`default_nettype none
module sgbs_top_tb_top;
	import sgbs_pkg::*;
	logic        clk, rst_b;           // Clock, reset active low
	logic        psel, penable, pwrite; // APB request
	logic [11:0] paddr;                // APB address
	logic [31:0] pwdata, prdata_o, rd; // Write, read, taken data
	logic        pready_o, pslverr_o, err, gsel, pmode, p_ctrl_o, second_o, seen;
	sgbs_posn_t  posn;                 // Positioning status
	sgbs_sense_t sense;                // Sensed values
	sgbs_gains_t gains_o;              // Blended gains
	logic [15:0] b1[8], b2[8], v;      // Expected bank contents
	int          fail_count, check_count, n;
	// Status per code that makes condition A true, and false
	logic [3:0]  pt[6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
	logic [3:0]  pf[6] = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h0, 4'h0};

	sgbs_top i_dut (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .pos_mode_i(pmode),
		.gain_sel_i(gsel), .sense_i(sense), .posn_i(posn), .gains_o(gains_o),
		.p_ctrl_o(p_ctrl_o), .second_o(second_o));
	sgbs_host_model i_host (.clk_i(clk), .gain_sel_o(gsel), .pos_mode_o(pmode),
		.posn_o(posn), .sense_o(sense));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Integral words are clamped, others kept as written
	function automatic logic [15:0] clampv(int i, logic [15:0] x);
		if (i != 1 && i != 6) return x;
		if (x < `SGBS_INTEG_MIN) return `SGBS_INTEG_MIN;
		return (x > `SGBS_INTEG_MAX) ? `SGBS_INTEG_MAX : x;
	endfunction
	function automatic logic [31:0] cfgw(logic [3:0] m, logic [2:0] c, logic l, logic p);
		return {22'h0, p, l, 1'b0, c, m};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// One APB transfer; holds everything until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk_gains(input logic sec);
		for (int i = 0; i < 8; i++) chk("gain", sec ? b2[i] : b1[i], gains_o[i]);
	endtask
	// Bounded wait for the settled bank flag; the caller judges it
	task automatic wait_sec(input logic e);
		n = 0;
		while (second_o !== e && n < 3000) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic finish_test;
		if (fail_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog: far beyond the expected run
	// ----------------------------------------
	initial begin
		repeat (90000) @(posedge clk);
		fail_count++;
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
		fail_count = 0;
		check_count = 0;
		b1 = '{`SGBS_RST_VGAIN, `SGBS_RST_INTEG, `SGBS_RST_PGAIN, `SGBS_RST_TFILT,
			`SGBS_RST_FFWD, `SGBS_RST_VGAIN, `SGBS_RST_INTEG, `SGBS_RST_PGAIN};
		b2 = b1;
		void'($urandom(70));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk_gains(1'b0);
		apb(1'b0, `SGBS_OFS_BANK1 + 12'h004, '0);
		chk("integ reset", 32'h7D0, rd);
		// Both range ends, then a random legal value
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 16'h0005 : (k == 1) ? 16'hFFFF : 16'($urandom_range(15, 51200));
			apb(1'b1, `SGBS_OFS_BANK1 + 12'h004, {16'h0, v});
			b1[1] = clampv(1, v);
			apb(1'b0, `SGBS_OFS_BANK1 + 12'h004, '0);
			chk("integ", {16'h0, b1[1]}, rd);
		end
		apb(1'b0, 12'h024, '0);
		chk("unmapped", 32'h1, {31'h0, err});
		chk("unmapped rd", 32'h0, rd);
		for (int i = 0; i < 8; i++) begin
			v = 16'($urandom_range(15, 20000));
			apb(1'b1, `SGBS_OFS_BANK2 + 12'(4 * i), {16'h0, v});
			b2[i] = clampv(i, v);
		end
		// Manual select follows the input
		i_host.drive(1'b1, 1'b0, 4'h0, 16'h0, 16'h0);
		repeat (3) @(posedge clk);
		chk_gains(1'b1);
		i_host.drive(1'b0, 1'b0, 4'h0, 16'h0, 16'h0);
		repeat (3) @(posedge clk);
		chk_gains(1'b0);
		apb(1'b1, `SGBS_OFS_CFG, 32'h1);
		apb(1'b0, `SGBS_OFS_CFG, '0);
		chk("mode", 32'h0, {28'h0, rd[3:0]});
		// Threshold edges: equal is not over, one above is
		v = 16'($urandom_range(100, 20000));
		apb(1'b1, `SGBS_OFS_ROT_ACC, {16'h0, v});
		apb(1'b1, `SGBS_OFS_LIN_ACC, {16'h0, v + 16'h0100});
		apb(1'b1, `SGBS_OFS_DEV_THR, {16'h0, v});
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `SGBS_OFS_CFG, cfgw(4'h0, 3'h0, k[1], 1'b0));
			i_host.drive(1'b0, 1'b0, 4'h0, v + (k[1] ? 16'h0100 : 16'h0) + 16'(k[0]), 16'h0);
			repeat (3) @(posedge clk);
			chk("p_ctrl acc", {31'h0, k[0]}, {31'h0, p_ctrl_o});
		end
		apb(1'b1, `SGBS_OFS_CFG, cfgw(4'h0, 3'h0, 1'b0, 1'b1));
		for (int k = 0; k < 4; k++) begin
			i_host.drive(1'b0, k[1], 4'h0, 16'h0, v + 16'(k[0]));
			repeat (3) @(posedge clk);
			chk("p_ctrl dev", {31'h0, k[0] & k[1]}, {31'h0, p_ctrl_o});
		end
		// Automatic: wait then ramp, each way
		apb(1'b1, `SGBS_OFS_WAIT1, 32'h1);
		apb(1'b1, `SGBS_OFS_WAIT2, 32'h2);
		apb(1'b1, `SGBS_OFS_RAMP1, 32'h2);
		apb(1'b1, `SGBS_OFS_RAMP2, 32'h1);
		apb(1'b1, `SGBS_OFS_CFG, cfgw(4'h2, 3'h0, 1'b0, 1'b0));
		i_host.drive(1'b0, 1'b1, 4'h8, 16'h0, 16'h0);
		wait_sec(1'b1);
		chk("up", 32'h1, {31'h0, second_o});
		chk("up time", 32'h1, {31'h0, n >= 300});
		chk_gains(1'b1);
		i_host.drive(1'b0, 1'b1, 4'h0, 16'h0, 16'h0);
		wait_sec(1'b0);
		chk("down", 32'h0, {31'h0, second_o});
		// Settled flag drops as the return wait starts; old bank must hold through it
		repeat (240) @(posedge clk);
		chk_gains(1'b1);
		n = 0;
		while ((gains_o[0] !== b1[0] || gains_o[2] !== b1[2]) && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("down time", 32'h1, {31'h0, n >= 100});
		chk_gains(1'b0);
		// Revert during a long wait must cancel the switch
		apb(1'b1, `SGBS_OFS_WAIT1, 32'h5);
		i_host.drive(1'b0, 1'b1, 4'h8, 16'h0, 16'h0);
		repeat (250) @(posedge clk);
		i_host.drive(1'b0, 1'b1, 4'h0, 16'h0, 16'h0);
		seen = 1'b0;
		repeat (1000) @(posedge clk) seen |= second_o;
		chk("cancel", 32'h0, {31'h0, seen});
		apb(1'b1, `SGBS_OFS_WAIT1, 32'h1);
		// Condition codes 0 to 5, inside and outside position control
		for (int c = 0; c < 6; c++) begin
			i_host.drive(1'b0, 1'b1, pf[c], 16'h0, 16'h0);
			apb(1'b1, `SGBS_OFS_CFG, cfgw(4'h2, 3'(c), 1'b0, 1'b0));
			wait_sec(1'b0);
			chk("cond off", 32'h0, {31'h0, second_o});
			i_host.drive(1'($urandom), 1'b1, pt[c], 16'h0, 16'h0);
			wait_sec(1'b1);
			chk("cond on", 32'h1, {31'h0, second_o});
			i_host.drive(1'($urandom), 1'b0, pt[c], 16'h0, 16'h0);
			wait_sec(1'(c));
			chk("fixed", 32'(c % 2), {31'h0, second_o});
		end
		finish_test();
	end
endmodule // sgbs_top_tb_top
`default_nettype wire
